// ---- rtl/tbo_top.sv ----
// Tone generator summed into the playback sample path, plus output enables.
// Assumes a same-clock register port and sample stream from the codec core.
`timescale 1ns/10ps
`default_nettype none
module tbo_top
    import tbo_pkg::*;
(
    // Clock and reset.
    input  wire logic                clk_in,
    input  wire logic                reset_n_in,
    // Register port.
    input  wire logic                reg_wr_en_in,
    input  wire logic                reg_rd_en_in,
    input  wire logic [ADDR_W-1:0]   reg_addr_in,
    input  wire logic [REG_W-1:0]    reg_wdata_in,
    output logic [REG_W-1:0]         reg_rdata_out,
    // Control levels held elsewhere in the codec.
    input  wire logic                conv_path_enable_in,
    input  wire logic                conv_mute_in,
    input  wire logic                zero_run_silencer_in,
    input  wire logic [1:0]          midrail_select_in,
    input  wire logic                bias_current_enable_in,
    input  wire logic                line_mute_in,
    input  wire logic                spk_mute_in,
    input  wire logic                spk_mixer_mute_in,
    input  wire logic                spk_gain_mute_in,
    // Playback samples after digital volume.
    input  wire logic                smp_valid_in,
    input  wire logic [SAMPLE_W-1:0] smp_data_in,
    output logic                     smp_ready_out,
    // Samples to the converter.
    output logic                     conv_valid_out,
    output logic [SAMPLE_W-1:0]      conv_data_out,
    input  wire logic                conv_ready_in,
    output logic                     conv_silence_out,
    // Analogue stage enables.
    output logic                     line_out_pin_enable_out,
    output logic                     spk_gain_stage_enable_out,
    output logic                     spk_mixer_enable_out,
    output logic                     spk_out_neg_enable_out,
    output logic                     spk_out_pos_enable_out
);
    logic [REG_W-1:0]        pwr_reg, pwr_next;
    logic [REG_W-1:0]        tone_reg, tone_next;
    logic [REG_W-1:0]        rdata_reg, rdata_next;
    logic [PHASE_W-1:0]      phase_reg, phase_next, inc;
    logic                    tone_enable;
    logic [1:0]              rate;
    logic [3:0]              level;
    logic [2:0]              idx;
    logic signed [16:0]      sine;
    logic signed [33:0]      prod, scaled;
    logic [4:0]              shift_amt;
    logic signed [17:0]      tone_val;
    logic signed [18:0]      sum_wide;
    logic [SAMPLE_W-1:0]     push_data;
    logic                    push, fifo_ready, fifo_valid, pop;
    logic [SAMPLE_W-1:0]     fifo_data;
    logic                    ov_reg, ov_next;
    logic [SAMPLE_W-1:0]     od_reg, od_next;
    logic [10:0]             zcnt_reg, zcnt_next;
    logic                    sil_reg, sil_next, nz;
    logic                    ref_ok;
    logic [4:0]              en_reg, en_next;

    // Register file. Reserved bits are not stored and read as zero.
    always_comb begin
        pwr_next   = pwr_reg;
        tone_next  = tone_reg;
        rdata_next = rdata_reg;
        if (reg_wr_en_in) begin
            if (reg_addr_in == ADDR_PWR_OUT) begin
                pwr_next = reg_wdata_in & PWR_OUT_WMASK;
            end else if (reg_addr_in == ADDR_TONE_CTRL) begin
                tone_next = reg_wdata_in & TONE_WMASK;
            end
        end
        if (reg_rd_en_in) begin
            if (reg_addr_in == ADDR_PWR_OUT) begin
                rdata_next = pwr_reg;
            end else if (reg_addr_in == ADDR_TONE_CTRL) begin
                rdata_next = tone_reg;
            end else begin
                rdata_next = '0;
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pwr_reg   <= PWR_OUT_RESET;
            tone_reg  <= TONE_RESET;
            rdata_reg <= '0;
        end else begin
            pwr_reg   <= pwr_next;
            tone_reg  <= tone_next;
            rdata_reg <= rdata_next;
        end
    end

    // Tone synthesis: quarter-wave table with mirrored index and sign.
    always_comb begin
        tone_enable = tone_reg[BIT_TONE_EN];
        rate        = tone_reg[RATE_LSB +: 2];
        level       = tone_reg[LEVEL_LSB +: 4];
        case (rate)
            RATE_1K: inc = INC_1K;
            RATE_2K: inc = INC_2K;
            RATE_4K: inc = INC_4K;
            default: inc = '0;
        endcase
        idx       = phase_reg[PHASE_W-2] ? ~phase_reg[PHASE_W-3 -: 3] : phase_reg[PHASE_W-3 -: 3];
        sine      = phase_reg[PHASE_W-1] ? -$signed({2'h0, SINE_Q[idx]})
                                         : $signed({2'h0, SINE_Q[idx]});
        prod      = sine * $signed(GAIN_MANT);
        // Binary shifts give 6.02 dB steps, close enough to the nominal 6 dB.
        shift_amt = GAIN_FRAC_W + 5'(LEVEL_MAX - level);
        scaled    = prod >>> shift_amt;
        if (!tone_enable || level == LEVEL_MUTE || rate == RATE_RSVD) begin
            tone_val = '0;
        end else begin
            tone_val = scaled[17:0];
        end
        // The incoming sample is already volume scaled; converter mute drops
        // it but never the tone.
        sum_wide = (conv_mute_in ? 19'sh0 : 19'(signed'(smp_data_in)))
                   + 19'(tone_val);
        if (sum_wide > SAT_MAX) begin
            push_data = SAT_MAX[SAMPLE_W-1:0];
        end else if (sum_wide < SAT_MIN) begin
            push_data = SAT_MIN[SAMPLE_W-1:0];
        end else begin
            push_data = sum_wide[SAMPLE_W-1:0];
        end
        push       = smp_valid_in && fifo_ready;
        phase_next = push ? phase_reg + inc : phase_reg;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_next;
        end
    end

    tbo_fifo #(
        .WIDTH (SAMPLE_W),
        .DEPTH (FIFO_DEPTH)
    ) tbo_fifo_i (
        .clk_in        (clk_in),
        .reset_n_in    (reset_n_in),
        .in_valid_in   (smp_valid_in),
        .in_data_in    (push_data),
        .in_ready_out  (fifo_ready),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_data),
        .out_ready_in  (pop)
    );

    // Output register stage and zero-run silencer on the converter side.
    always_comb begin
        pop     = fifo_valid && (!ov_reg || conv_ready_in);
        ov_next = ov_reg;
        od_next = od_reg;
        if (pop) begin
            ov_next = 1'h1;
            od_next = fifo_data;
        end else if (conv_ready_in) begin
            ov_next = 1'h0;
        end
        nz        = ov_reg && od_reg != '0;
        zcnt_next = zcnt_reg;
        if (nz) begin
            zcnt_next = '0;
        end else if (ov_reg && conv_ready_in && zcnt_reg != ZERO_RUN) begin
            zcnt_next = zcnt_reg + 1'h1;
        end
        // Counting runs even while disabled so enabling it acts at once.
        sil_next = zero_run_silencer_in && !nz && zcnt_next == ZERO_RUN;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ov_reg   <= 1'h0;
            od_reg   <= '0;
            zcnt_reg <= '0;
            sil_reg  <= 1'h0;
        end else begin
            ov_reg   <= ov_next;
            od_reg   <= od_next;
            zcnt_reg <= zcnt_next;
            sil_reg  <= sil_next;
        end
    end

    // Analogue enables. Stages that need the reference stay off without it.
    always_comb begin
        ref_ok     = bias_current_enable_in && midrail_select_in != 2'h0;
        en_next[0] = pwr_reg[BIT_LINE_EN] && !line_mute_in;
        en_next[1] = pwr_reg[BIT_GAIN_STG_EN] && !spk_gain_mute_in && ref_ok;
        en_next[2] = pwr_reg[BIT_MIXER_EN] && !spk_mixer_mute_in && ref_ok;
        en_next[3] = pwr_reg[BIT_NEG_SUPPLY] && pwr_reg[BIT_NEG_STAGE] && !spk_mute_in;
        en_next[4] = pwr_reg[BIT_POS_SUPPLY] && pwr_reg[BIT_POS_STAGE] && !spk_mute_in;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            en_reg <= '0;
        end else begin
            en_reg <= en_next;
        end
    end

    assign reg_rdata_out             = rdata_reg;
    assign smp_ready_out             = fifo_ready;
    assign conv_valid_out            = ov_reg;
    assign conv_data_out             = od_reg;
    assign conv_silence_out          = sil_reg;
    assign line_out_pin_enable_out   = en_reg[0];
    assign spk_gain_stage_enable_out = en_reg[1];
    assign spk_mixer_enable_out      = en_reg[2];
    assign spk_out_neg_enable_out    = en_reg[3];
    assign spk_out_pos_enable_out    = en_reg[4];

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    AST_TONE_OFF: assert property (
        push && !tone_enable && !conv_mute_in |-> push_data == smp_data_in)
        else $error("Disabled tone changed the sample.");
    AST_LEVEL_MUTE: assert property (
        level == LEVEL_MUTE |-> tone_val == '0)
        else $error("Level zero did not mute the tone.");
    AST_RATE_2K: assert property (
        push && rate == RATE_2K |=> phase_reg == $past(phase_reg) + INC_2K)
        else $error("Phase step wrong for the 2 kHz rate.");
    AST_PHASE_HOLD: assert property (
        !push |=> $stable(phase_reg))
        else $error("Phase moved without a sample.");
    AST_SUM: assert property (
        push && !conv_mute_in && sum_wide <= SAT_MAX && sum_wide >= SAT_MIN
        |-> push_data == SAMPLE_W'(signed'(smp_data_in) + tone_val))
        else $error("Tone not summed into the sample.");
    AST_SAT: assert property (
        push && sum_wide > SAT_MAX |-> push_data == SAT_MAX[SAMPLE_W-1:0])
        else $error("Positive overflow not saturated.");
    AST_MUTE_INDEP: assert property (
        push && conv_mute_in && level != LEVEL_MAX |-> push_data == SAMPLE_W'(tone_val))
        else $error("Converter mute affected the tone.");
    AST_SPK_NEG: assert property (
        ##1 spk_out_neg_enable_out == ($past(pwr_reg[BIT_NEG_SUPPLY])
            && $past(pwr_reg[BIT_NEG_STAGE]) && !$past(spk_mute_in)))
        else $error("Negative half enable wrong.");
    AST_SPK_POS: assert property (
        ##1 spk_out_pos_enable_out == ($past(pwr_reg[BIT_POS_SUPPLY])
            && $past(pwr_reg[BIT_POS_STAGE]) && !$past(spk_mute_in)))
        else $error("Positive half enable wrong.");
    AST_LINE: assert property (
        !pwr_reg[BIT_LINE_EN] |=> !line_out_pin_enable_out)
        else $error("Line output on while disabled.");
    AST_SILENCE: assert property (
        zero_run_silencer_in && zcnt_reg == ZERO_RUN && !nz |=> conv_silence_out)
        else $error("Zero run did not silence.");
    AST_RESUME: assert property (
        nz |=> !conv_silence_out)
        else $error("Silence held over nonzero data.");
    AST_RATE_1K: assert property (
        push && rate == RATE_1K |=> phase_reg == $past(phase_reg) + INC_1K)
        else $error("Phase step wrong for the 1 kHz rate.");
    AST_RATE_RSVD: assert property (
        rate == RATE_RSVD |-> tone_val == '0)
        else $error("Reserved rate produced a tone.");
    AST_MIXER: assert property (
        !pwr_reg[BIT_MIXER_EN] |=> !spk_mixer_enable_out)
        else $error("Speaker mixer on while disabled.");
    AST_GAIN_REF: assert property (
        !bias_current_enable_in || midrail_select_in == 2'h0 |=> !spk_gain_stage_enable_out)
        else $error("Gain stage on without reference.");
    AST_LINE_MUTE: assert property (
        line_mute_in |=> !line_out_pin_enable_out)
        else $error("Line output on while muted.");

    COV_TONE_4K: cover property (push && tone_enable && rate == RATE_4K && level == LEVEL_MAX);
    COV_SAT: cover property (push && sum_wide > SAT_MAX);
    COV_SILENCE: cover property ($rose(conv_silence_out));
    COV_FULL: cover property (smp_valid_in && !fifo_ready);
endmodule // tbo_top
`default_nettype wire

// ---- common/tbo_pkg.sv ----
// Package for the tone beep and output enable block: register map, fields,
// reset values and tone constants.
// Assumes a 25 MHz core clock and a fixed playback sample rate.
package tbo_pkg;
    localparam int              SAMPLE_W        = 16;
    localparam int              ADDR_W          = 7;
    localparam int              REG_W           = 16;
    localparam int              FIFO_DEPTH      = 4;
    localparam logic [6:0]      ADDR_PWR_OUT    = 7'h03;
    localparam logic [6:0]      ADDR_TONE_CTRL  = 7'h25;
    localparam logic [15:0]     PWR_OUT_RESET   = 16'h0000;
    localparam logic [15:0]     PWR_OUT_WMASK   = 16'h5CC4;
    localparam logic [15:0]     TONE_RESET      = 16'h0002;
    localparam logic [15:0]     TONE_WMASK      = 16'h007F;
    localparam int              BIT_LINE_EN     = 14;
    localparam int              BIT_GAIN_STG_EN = 12;
    localparam int              BIT_NEG_SUPPLY  = 11;
    localparam int              BIT_POS_SUPPLY  = 10;
    localparam int              BIT_NEG_STAGE   = 7;
    localparam int              BIT_POS_STAGE   = 6;
    localparam int              BIT_MIXER_EN    = 2;
    localparam int              BIT_TONE_EN     = 0;
    localparam int              RATE_LSB        = 1;
    localparam int              LEVEL_LSB       = 3;
    localparam logic [1:0]      RATE_RSVD       = 2'h0;
    localparam logic [1:0]      RATE_1K         = 2'h1;
    localparam logic [1:0]      RATE_2K         = 2'h2;
    localparam logic [1:0]      RATE_4K         = 2'h3;
    localparam logic [3:0]      LEVEL_MUTE      = 4'h0;
    localparam logic [3:0]      LEVEL_MAX       = 4'hF;
    localparam int              SAMPLE_RATE_HZ  = 48000;
    localparam int              TONE_1K_HZ      = 1000;
    localparam int              TONE_2K_HZ      = 2000;
    localparam int              TONE_4K_HZ      = 4000;
    localparam int              PHASE_W         = 16;
    localparam int              PHASE_FULL      = 65536;
    localparam logic [15:0]     INC_1K          = 16'((TONE_1K_HZ * PHASE_FULL) / SAMPLE_RATE_HZ);
    localparam logic [15:0]     INC_2K          = 16'((TONE_2K_HZ * PHASE_FULL) / SAMPLE_RATE_HZ);
    localparam logic [15:0]     INC_4K          = 16'((TONE_4K_HZ * PHASE_FULL) / SAMPLE_RATE_HZ);
    // Level 1111 is +1 dB: mantissa 1.122 in Q2.14, each lower code down to 0001 halves; 0000 mutes.
    localparam logic [4:0]      GAIN_FRAC_W     = 5'h0E;
    localparam logic [16:0]     GAIN_MANT       = 17'h047CF;
    localparam logic [10:0]     ZERO_RUN        = 11'h400;
    localparam logic signed [18:0] SAT_MAX      = 19'sh07FFF;
    localparam logic signed [18:0] SAT_MIN      = -19'sh08000;
    localparam logic [14:0]     SINE_Q [8]      = '{15'h0C8C, 15'h2528, 15'h3C57,
                                                    15'h5134, 15'h62F2, 15'h70E2,
                                                    15'h7A7C, 15'h7F61};
endpackage

// ---- rtl/tbo_fifo.sv ----
// Small synchronous FIFO in flip-flops for the tone block's sample path.
// Assumes one clock; the reader may stall so the FIFO really fills.
`timescale 1ns/10ps
`default_nettype none
module tbo_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset.
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // Filling side.
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    // Draining side.
    output logic                  out_valid_out,
    output logic [WIDTH-1:0]      out_data_out,
    input  wire logic             out_ready_in
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
    logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
    logic [PW:0]      count_reg, count_next;
    logic             ready_reg, ready_next;
    logic             push, pop;

    always_comb begin
        push        = in_valid_in && ready_reg;
        pop         = out_valid_out && out_ready_in;
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'h1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'h1;
        end
        count_next = count_reg + (PW+1)'(push) - (PW+1)'(pop);
        ready_next = count_next < DEPTH_C;
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'h1;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            ready_reg  <= ready_next;
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_in or negedge reset_n_in) begin
            if (!reset_n_in) begin
                mem_reg[i] <= '0;
            end else if (push && wr_ptr_reg == PW'(i)) begin
                mem_reg[i] <= in_data_in;
            end
        end
    end

    assign in_ready_out  = ready_reg;
    assign out_valid_out = count_reg != '0;
    assign out_data_out  = mem_reg[rd_ptr_reg];
endmodule // tbo_fifo
`default_nettype wire

// ---- verif/tbo_top_test.sv ----
// Self-checking bench for the tone and output enable block.
// Assumes the bench drives every port of the block directly, on the falling edge.
`timescale 1ns/10ps
`default_nettype none
module tbo_top_test;
    import tbo_pkg::*;
    logic        clk, rst_n, wr_en, rd_en, cmute, zsil, bias, sv, crdy;
    logic [6:0]  addr;
    logic [15:0] wdata, rdata, sd, cd, r;
    logic [1:0]  mid;
    logic [3:0]  mutes;
    logic        srdy, cv, csil;
    logic [4:0]  en;
    logic [15:0] got_q[$];
    int          n_fail, comparisons, n;
    // Power word, mutes (line, speaker, mixer, gain), reference, expected enables.
    // The last three rows raise a stage before its supply and drop the supply first.
    logic [25:0] rows [14] = '{
        {16'h5CC4, 4'h0, 1'h1, 5'h1F}, {16'h5CC4, 4'hF, 1'h1, 5'h00},
        {16'h5CC4, 4'h0, 1'h0, 5'h13}, {16'h5CC4, 4'h4, 1'h1, 5'h1C},
        {16'h5CC4, 4'h8, 1'h1, 5'h0F}, {16'h5CC4, 4'h2, 1'h1, 5'h1B},
        {16'h5CC4, 4'h1, 1'h1, 5'h17}, {16'h0880, 4'h0, 1'h1, 5'h02},
        {16'h0840, 4'h0, 1'h1, 5'h00}, {16'h0440, 4'h0, 1'h1, 5'h01},
        {16'h1004, 4'h0, 1'h1, 5'h0C}, {16'h0040, 4'h0, 1'h1, 5'h00},
        {16'h0440, 4'h0, 1'h1, 5'h01}, {16'h0040, 4'h0, 1'h1, 5'h00}};

    tbo_top tbo_top_i (
        .clk_in(clk), .reset_n_in(rst_n), .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .conv_path_enable_in(1'h1), .conv_mute_in(cmute), .zero_run_silencer_in(zsil),
        .midrail_select_in(mid), .bias_current_enable_in(bias),
        .line_mute_in(mutes[3]), .spk_mute_in(mutes[2]), .spk_mixer_mute_in(mutes[1]),
        .spk_gain_mute_in(mutes[0]), .smp_valid_in(sv), .smp_data_in(sd),
        .smp_ready_out(srdy), .conv_valid_out(cv), .conv_data_out(cd),
        .conv_ready_in(crdy), .conv_silence_out(csil),
        .line_out_pin_enable_out(en[4]), .spk_gain_stage_enable_out(en[3]),
        .spk_mixer_enable_out(en[2]), .spk_out_neg_enable_out(en[1]),
        .spk_out_pos_enable_out(en[0]));

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    // Words are captured where the converter really takes them.
    always @(posedge clk) begin
        if (cv === 1'h1 && crdy === 1'h1) got_q.push_back(cd);
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic close_out;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic timed_out(input string what);
        n_fail++;
        $display("wrong value %s expected progress seen none", what);
        close_out();
    endtask

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge clk);
        wr_en = 1'h1;
        addr = a;
        wdata = d;
        @(negedge clk);
        wr_en = 1'h0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(negedge clk);
        rd_en = 1'h1;
        addr = a;
        @(negedge clk);
        rd_en = 1'h0;
        @(negedge clk);
        d = rdata;
    endtask

    // Holds the sample until the FIFO has room, then releases it after the taking edge.
    task automatic send(input logic [15:0] d);
        int i;
        @(negedge clk);
        sv = 1'h1;
        sd = d;
        for (i = 0; srdy !== 1'h1; i++) begin
            if (i > 50) timed_out("sample_take");
            @(negedge clk);
        end
        @(negedge clk);
        sv = 1'h0;
    endtask

    task automatic take(input logic [15:0] d, output logic [15:0] res);
        int i;
        got_q.delete();
        send(d);
        for (i = 0; got_q.size() == 0; i++) begin
            if (i > 20) timed_out("conv_word");
            @(negedge clk);
        end
        res = got_q.pop_front();
    endtask

    task automatic do_reset;
        rst_n = 1'h0;
        repeat (12) @(negedge clk);
        chk("enables_in_reset", 16'h0000, {11'h000, en});
        chk("ready_in_reset", 16'h0001, {15'h0000, srdy});
        rst_n = 1'h1;
        $display("done: reset");
    endtask

    initial begin
        {wr_en, rd_en, cmute, zsil, sv} = 5'h00;
        {addr, wdata, sd} = '0;
        mutes = 4'hF;
        mid = 2'h1;
        bias = 1'h1;
        crdy = 1'h1;
        n_fail = 0;
        comparisons = 0;
        do_reset();
        rd(ADDR_PWR_OUT, r);
        chk("pwr_reset", 16'h0000, r);
        rd(ADDR_TONE_CTRL, r);
        chk("tone_reset", 16'h0002, r);
        wr(ADDR_PWR_OUT, 16'hFFFF);
        rd(ADDR_PWR_OUT, r);
        chk("pwr_mask", 16'h5CC4, r);
        chk("muted_after_reset", 16'h0000, {11'h000, en});
        wr(ADDR_TONE_CTRL, 16'hFFFF);
        rd(ADDR_TONE_CTRL, r);
        chk("tone_mask", 16'h007F, r);
        wr(7'h10, 16'hFFFF);
        rd(7'h10, r);
        chk("unmapped_read", 16'h0000, r);
        wr(ADDR_TONE_CTRL, 16'h0002);
        $display("done: registers");
        foreach (rows[k]) begin
            @(negedge clk);
            mutes = rows[k][9:6];
            mid = {1'h0, rows[k][5]};
            wr(ADDR_PWR_OUT, rows[k][25:10]);
            repeat (3) @(negedge clk);
            chk("enables", {11'h000, rows[k][4:0]}, {11'h000, en});
        end
        $display("done: enables");
        take(16'h1234, r);
        chk("no_tone_pass", 16'h1234, r);
        cmute = 1'h1;
        take(16'h1234, r);
        chk("mute_no_tone", 16'h0000, r);
        cmute = 1'h0;
        $display("done: passthrough");
        // Converter stalls so the FIFO and the output register both fill up.
        crdy = 1'h0;
        got_q.delete();
        n = 0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (srdy === 1'h1) begin
                sv = 1'h1;
                sd = 16'h0100 + 16'(n);
                n++;
            end else begin
                sv = 1'h0;
            end
        end
        chk("fifo_refuses", 16'h0000, {15'h0000, srdy});
        // Four words wait in the buffer and one in the converter-side register.
        chk("fifo_holds_depth", 16'(FIFO_DEPTH + 1), 16'(n));
        crdy = 1'h1;
        repeat (12) @(negedge clk);
        chk("drain_count", 16'(n), 16'(got_q.size()));
        for (int i = 0; i < n; i++) chk("drain_order", 16'h0100 + 16'(i), got_q[i]);
        chk("fifo_empty", 16'h0000, {15'h0000, cv});
        $display("done: buffer");
        zsil = 1'h1;
        @(negedge clk);
        sv = 1'h1;
        sd = 16'h0000;
        repeat (1000) @(negedge clk);
        chk("silence_early", 16'h0000, {15'h0000, csil});
        repeat (40) @(negedge clk);
        chk("silence_after_run", 16'h0001, {15'h0000, csil});
        sv = 1'h0;
        send(16'h0001);
        repeat (4) @(negedge clk);
        chk("silence_resumes", 16'h0000, {15'h0000, csil});
        zsil = 1'h0;
        $display("done: silencer");
        // A fresh reset puts the phase at zero so tone samples are known.
        do_reset();
        wr(ADDR_TONE_CTRL, 16'h007F);
        take(16'h7FF0, r);
        chk("tone_saturates", 16'h7FFF, r);
        cmute = 1'h1;
        take(16'h1111, r);
        chk("tone_4k_muted_conv", 16'h43B3, r);
        wr(ADDR_TONE_CTRL, 16'h0077);
        take(16'h0000, r);
        chk("tone_level_step", 16'h3F53, r);
        cmute = 1'h0;
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_TONE_CTRL, j == 0 ? 16'h0007 : 16'h0079);
            take(16'h1234, r);
            chk("tone_silent_code", 16'h1234, r);
        end
        wr(ADDR_TONE_CTRL, 16'h007D);
        take(16'h0010, r);
        chk("tone_2k_sum", 16'h7EB7, r);
        wr(ADDR_TONE_CTRL, 16'h007B);
        take(16'hFFFF, r);
        chk("tone_1k_sum", 16'h6F03, r);
        $display("done: tone");
        close_out();
    end
endmodule // tbo_top_test
`default_nettype wire
